/* File: hdl/adder_pkg.sv */
// constants, field layout and state type of the add execution unit
// assumes one core clock; shared by the unit top and its core
package adder_pkg;
   // word and register-memory geometry
   localparam int DATA_W = 32;
   localparam int FIELD_W = 9;
   localparam int MEM_DEPTH = 512;
   localparam int ADDR_W = 10;
   localparam int OP_W = 6;
   localparam int COND_W = 4;

   // instruction word field positions
   localparam int OP_LSB = 26;
   localparam int ZWR_BIT = 25;
   localparam int CWR_BIT = 24;
   localparam int RWR_BIT = 23;
   localparam int IMM_BIT = 22;
   localparam int COND_LSB = 18;
   localparam int DEST_LSB = 9;
   localparam int SRC_LSB = 0;

   // operation codes
   localparam logic [OP_W-1:0] OP_SIGNED_ADD = 6'h34;
   localparam logic [OP_W-1:0] OP_SIGNED_ADDC = 6'h36;
   localparam logic [OP_W-1:0] OP_UNSIGNED_ADDC = 6'h32;
   localparam logic [COND_W-1:0] COND_ALWAYS = 4'hF;

   // clocks per instruction, accept cycle included
   localparam int EXEC_CLOCKS = 4;

   // register port map, word indices
   localparam logic [ADDR_W-1:0] FLAGS_ADDR = 10'h200;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h201;
   localparam int FLAG_Z_BIT = 0;
   localparam int FLAG_C_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_BADOP_BIT = 1;
   localparam logic RESET_FLAG = 1'b0;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CALC, ST_WRITE} state_e;
endpackage

/* File: hdl/adder_if.sv */
// operand and result bundle between the unit top and its add core
// assumes the core is purely combinational
`timescale 1ns/10ps
`default_nettype none
interface adder_if;
   logic [adder_pkg::OP_W-1:0] op;
   logic [adder_pkg::DATA_W-1:0] dVal;
   logic [adder_pkg::DATA_W-1:0] sVal;
   logic cIn;
   logic zIn;
   logic [adder_pkg::DATA_W-1:0] sum;
   logic zOut;
   logic cOut;
   logic known;
   modport core (input op, dVal, sVal, cIn, zIn,
      output sum, zOut, cOut, known);
   modport user (output op, dVal, sVal, cIn, zIn,
      input sum, zOut, cOut, known);
endinterface
`default_nettype wire

/* File: hdl/reg_memory.sv */
// register memory: 512 words, three registered read ports, one write
// assumes the caller arbitrates the single write port
`timescale 1ns/10ps
`default_nettype none
module reg_memory (
   input wire logic mclk,
   input wire logic [adder_pkg::FIELD_W-1:0] rdAddrA,
   input wire logic [adder_pkg::FIELD_W-1:0] rdAddrB,
   input wire logic [adder_pkg::FIELD_W-1:0] rdAddrC,
   output logic [adder_pkg::DATA_W-1:0] rdDataA,
   output logic [adder_pkg::DATA_W-1:0] rdDataB,
   output logic [adder_pkg::DATA_W-1:0] rdDataC,
   input wire logic wrEn,
   input wire logic [adder_pkg::FIELD_W-1:0] wrAddr,
   input wire logic [adder_pkg::DATA_W-1:0] wrData
);
   logic [adder_pkg::DATA_W-1:0] mem [adder_pkg::MEM_DEPTH];

   // read before write: a same-cycle read sees the old word
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
      rdDataC <= mem[rdAddrC];
   end
endmodule
`default_nettype wire

/* File: hdl/add_core.sv */
// combinational adder for the three add operations and their flags
// assumes operands and incoming flags are held stable by the caller
`timescale 1ns/10ps
`default_nettype none
module add_core (
   adder_if.core bus
);
   logic [adder_pkg::DATA_W:0] wide;
   logic carryUsed;
   logic allZero;
   logic overflow;

   // carry joins every operation except the plain signed add
   always_comb begin
      carryUsed = (bus.op != adder_pkg::OP_SIGNED_ADD) && bus.cIn;
      wide = {1'b0, bus.dVal} + {1'b0, bus.sVal}
         + {{adder_pkg::DATA_W{1'b0}}, carryUsed};
      allZero = (wide[adder_pkg::DATA_W-1:0] == '0);
      // sign rule holds with carry in, so one detector serves both
      overflow = (bus.dVal[31] == bus.sVal[31]) && (wide[31] != bus.dVal[31]);
   end

   // flag results per operation
   always_comb begin
      bus.sum = wide[adder_pkg::DATA_W-1:0];
      bus.known = 1'b1;
      bus.zOut = 1'b0;
      bus.cOut = 1'b0;
      case (bus.op)
         adder_pkg::OP_SIGNED_ADD: begin
            bus.zOut = allZero;
            bus.cOut = overflow;
         end
         adder_pkg::OP_SIGNED_ADDC: begin
            bus.zOut = bus.zIn && allZero;
            bus.cOut = overflow;
         end
         adder_pkg::OP_UNSIGNED_ADDC: begin
            bus.zOut = bus.zIn && allZero;
            bus.cOut = wide[adder_pkg::DATA_W];
         end
         default: begin
            bus.known = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: hdl/add_unit.sv */
// add execution unit: decode, register memory, flags and register port
// assumes instructions come from same-clock decoder logic, no sync
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module add_unit (
   input wire logic mclk,
   input wire logic reset,
   input wire logic instrValid,
   input wire logic [adder_pkg::DATA_W-1:0] instrWord,
   output logic instrReady,
   output logic instrDone,
   input wire logic [adder_pkg::ADDR_W-1:0] busAddr,
   input wire logic [adder_pkg::DATA_W-1:0] busWrData,
   input wire logic busWr,
   input wire logic busRd,
   output logic [adder_pkg::DATA_W-1:0] busRdData,
   output logic zeroFlag,
   output logic carryFlag
);
   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   adder_pkg::state_e state_r, state_nxt;
   logic [adder_pkg::DATA_W-1:0] instr_r, instr_nxt;
   logic [adder_pkg::DATA_W-1:0] res_r, res_nxt;
   logic zRes_r, zRes_nxt, cRes_r, cRes_nxt;
   logic exec_r, exec_nxt;
   logic zFlag_r, zFlag_nxt, cFlag_r, cFlag_nxt;
   logic badOp_r, badOp_nxt;
   logic [1:0] rdSel_r, rdSel_nxt;
   logic [adder_pkg::DATA_W-1:0] rdReg_r, rdReg_nxt;
   logic accept;
   logic opKnown;
   logic memWe;
   logic [adder_pkg::FIELD_W-1:0] memWaddr;
   logic [adder_pkg::DATA_W-1:0] memWdata;
   logic [adder_pkg::DATA_W-1:0] memDest, memSrc, memBus;
   logic [adder_pkg::DATA_W-1:0] sOp;
   logic [adder_pkg::OP_W-1:0] opField;
   logic [adder_pkg::COND_W-1:0] condField;
   logic [adder_pkg::FIELD_W-1:0] destField, srcField;
   logic zWrite, cWrite, rWrite, immSel;
   logic flagWr, statWr, memBusWr;
   adder_if core();

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // condition table indexed by the current carry and zero flags
   function automatic logic cond_passes(
      input logic [adder_pkg::COND_W-1:0] cond,
      input logic c,
      input logic z);
      cond_passes = cond[{c, z}];
   endfunction

   // field extraction, used on the latched word
   function automatic logic [adder_pkg::FIELD_W-1:0] field9(
      input logic [adder_pkg::DATA_W-1:0] w,
      input int lsb);
      field9 = w[lsb +: adder_pkg::FIELD_W];
   endfunction

   // -------------------------------------------------------------
   // instruction decode
   // -------------------------------------------------------------
   assign opField = instr_r[adder_pkg::OP_LSB +: adder_pkg::OP_W];
   assign condField = instr_r[adder_pkg::COND_LSB +: adder_pkg::COND_W];
   assign destField = field9(instr_r, adder_pkg::DEST_LSB);
   assign srcField = field9(instr_r, adder_pkg::SRC_LSB);
   assign zWrite = instr_r[adder_pkg::ZWR_BIT];
   assign cWrite = instr_r[adder_pkg::CWR_BIT];
   assign rWrite = instr_r[adder_pkg::RWR_BIT];
   assign immSel = instr_r[adder_pkg::IMM_BIT];

   // handshake is combinational; one instruction in flight at a time
   assign instrReady = (state_r == adder_pkg::ST_IDLE);
   assign instrDone = (state_r == adder_pkg::ST_WRITE);
   assign accept = instrValid && instrReady;

   // immediate is zero-extended, so negative literals are not possible
   assign sOp = immSel ? {{(adder_pkg::DATA_W-adder_pkg::FIELD_W){1'b0}},
      srcField} : memSrc;

   // -------------------------------------------------------------
   // datapath
   // -------------------------------------------------------------
   assign core.op = opField;
   assign core.dVal = memDest;
   assign core.sVal = sOp;
   assign core.cIn = cFlag_r;
   assign core.zIn = zFlag_r;
   assign opKnown = core.known;

   add_core adder (
      .bus(core)
   );

   // bus read port C shares the memory; execution owns ports A and B
   reg_memory regs (
      .mclk(mclk),
      .rdAddrA(destField),
      .rdAddrB(srcField),
      .rdAddrC(busAddr[adder_pkg::FIELD_W-1:0]),
      .rdDataA(memDest),
      .rdDataB(memSrc),
      .rdDataC(memBus),
      .wrEn(memWe),
      .wrAddr(memWaddr),
      .wrData(memWdata)
   );

   // -------------------------------------------------------------
   // write port arbitration
   // -------------------------------------------------------------
   assign memBusWr = busWr && !busAddr[adder_pkg::ADDR_W-1];
   assign flagWr = busWr && (busAddr == adder_pkg::FLAGS_ADDR);
   assign statWr = busWr && (busAddr == adder_pkg::STATUS_ADDR);

   // execution write wins; a colliding software write is dropped
   always_comb begin
      memWe = memBusWr;
      memWaddr = busAddr[adder_pkg::FIELD_W-1:0];
      memWdata = busWrData;
      if (state_r == adder_pkg::ST_WRITE && exec_r && rWrite) begin
         memWe = 1'b1;
         memWaddr = destField;
         memWdata = res_r;
      end
   end

   // -------------------------------------------------------------
   // sequencer and flags: next state
   // -------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      instr_nxt = instr_r;
      res_nxt = res_r;
      zRes_nxt = zRes_r;
      cRes_nxt = cRes_r;
      exec_nxt = exec_r;
      zFlag_nxt = zFlag_r;
      cFlag_nxt = cFlag_r;
      badOp_nxt = badOp_r;
      // software flag writes go first so execution overrides them
      if (flagWr) begin
         zFlag_nxt = busWrData[adder_pkg::FLAG_Z_BIT];
         cFlag_nxt = busWrData[adder_pkg::FLAG_C_BIT];
      end
      if (statWr && busWrData[adder_pkg::STAT_BADOP_BIT]) begin
         badOp_nxt = 1'b0;
      end
      case (state_r)
         adder_pkg::ST_IDLE: begin
            if (accept) begin
               instr_nxt = instrWord;
               state_nxt = adder_pkg::ST_READ;
            end
         end
         adder_pkg::ST_READ: begin
            state_nxt = adder_pkg::ST_CALC;
         end
         adder_pkg::ST_CALC: begin
            res_nxt = core.sum;
            zRes_nxt = core.zOut;
            cRes_nxt = core.cOut;
            exec_nxt = opKnown && cond_passes(condField, cFlag_r, zFlag_r);
            if (!opKnown) begin
               badOp_nxt = 1'b1; // set wins over the clear above
            end
            state_nxt = adder_pkg::ST_WRITE;
         end
         adder_pkg::ST_WRITE: begin
            if (exec_r && zWrite) begin
               zFlag_nxt = zRes_r;
            end
            if (exec_r && cWrite) begin
               cFlag_nxt = cRes_r;
            end
            state_nxt = adder_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = adder_pkg::ST_IDLE;
         end
      endcase
   end

   // -------------------------------------------------------------
   // register read path
   // -------------------------------------------------------------
   // memory words come from the memory's own output register
   always_comb begin
      rdSel_nxt = 2'h0;
      rdReg_nxt = '0;
      if (busRd) begin
         if (!busAddr[adder_pkg::ADDR_W-1]) begin
            rdSel_nxt = 2'h1;
         end else if (busAddr == adder_pkg::FLAGS_ADDR) begin
            rdReg_nxt[adder_pkg::FLAG_Z_BIT] = zFlag_r;
            rdReg_nxt[adder_pkg::FLAG_C_BIT] = cFlag_r;
         end else if (busAddr == adder_pkg::STATUS_ADDR) begin
            rdReg_nxt[adder_pkg::STAT_BUSY_BIT] = !instrReady;
            rdReg_nxt[adder_pkg::STAT_BADOP_BIT] = badOp_r;
         end
      end
   end

   assign busRdData = (rdSel_r == 2'h1) ? memBus : rdReg_r;
   assign zeroFlag = zFlag_r;
   assign carryFlag = cFlag_r;

   // -------------------------------------------------------------
   // state registers
   // -------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= adder_pkg::ST_IDLE;
         instr_r <= '0;
         res_r <= '0;
         zRes_r <= 1'b0;
         cRes_r <= 1'b0;
         exec_r <= 1'b0;
         zFlag_r <= adder_pkg::RESET_FLAG;
         cFlag_r <= adder_pkg::RESET_FLAG;
         badOp_r <= 1'b0;
         rdSel_r <= 2'h0;
         rdReg_r <= '0;
      end else begin
         state_r <= state_nxt;
         instr_r <= instr_nxt;
         res_r <= res_nxt;
         zRes_r <= zRes_nxt;
         cRes_r <= cRes_nxt;
         exec_r <= exec_nxt;
         zFlag_r <= zFlag_nxt;
         cFlag_r <= cFlag_nxt;
         badOp_r <= badOp_nxt;
         rdSel_r <= rdSel_nxt;
         rdReg_r <= rdReg_nxt;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   logic [adder_pkg::DATA_W-1:0] dHold_r, sHold_r;
   logic cHold_r;
   always_ff @(posedge mclk) begin
      if (state_r == adder_pkg::ST_CALC) begin
         dHold_r <= memDest;
         sHold_r <= sOp;
         cHold_r <= cFlag_r;
      end
   end

   sequence s_issue;
      accept ##1 (state_r == adder_pkg::ST_READ);
   endsequence
   sequence s_doneOnce;
      !instrDone ##1 !instrDone ##1 instrDone ##1 !instrDone;
   endsequence
   logic wrSigned, wrChain;
   assign wrSigned = instrDone && exec_r
      && opField == adder_pkg::OP_SIGNED_ADD;
   assign wrChain = instrDone && exec_r && opField != adder_pkg::OP_SIGNED_ADD;

   a_four_clocks: assert property (s_issue |-> s_doneOnce)
      else $error("instruction did not finish in four clocks");
   a_signed_sum: assert property (wrSigned && rWrite |->
      memWe && memWdata == dHold_r + sHold_r)
      else $error("signed add wrote a wrong sum");
   a_carry_sum: assert property (wrChain && rWrite |-> memWdata ==
      dHold_r + sHold_r + {31'h0, cHold_r})
      else $error("carry add wrote a wrong total");
   a_imm_source: assert property (state_r == adder_pkg::ST_CALC
      && immSel |-> sOp == {23'h0, srcField})
      else $error("immediate operand not zero-extended field");
   a_zero_plain: assert property (wrSigned && zWrite |=>
      zFlag_r == ($past(res_r) == 32'h0))
      else $error("zero flag wrong after signed add");
   a_no_write: assert property (instrDone && !rWrite && !$past(busWr)
      |-> !(memWe && memWaddr == destField && !memBusWr))
      else $error("destination written with result write off");
   a_zero_chain: assert property (wrChain && zWrite |=>
      zFlag_r == ($past(zFlag_r) && $past(res_r) == 32'h0))
      else $error("chained zero flag wrong");
   a_unsigned_carry: assert property (wrChain && cWrite && opField ==
      adder_pkg::OP_UNSIGNED_ADDC |=> cFlag_r == ({1'b0, $past(dHold_r)} +
      {1'b0, $past(sHold_r)} + {32'h0, $past(cHold_r)} > 33'h0FFFFFFFF))
      else $error("unsigned carry flag wrong");
   a_cond_skip: assert property (instrDone && !exec_r |=>
      $stable(zFlag_r) || $past(flagWr))
      else $error("skipped instruction changed a flag");
endmodule
`default_nettype wire

/* File: verification/instr_feeder.sv */
// instruction source model: offers one word and holds it until taken
// assumes the unit takes a word on an edge with instrValid and instrReady
`timescale 1ns/10ps
`default_nettype none
module instr_feeder (
   input wire logic mclk,
   input wire logic reset,
   input wire logic go,
   input wire logic [31:0] goWord,
   input wire logic instrReady,
   output logic instrValid,
   output logic [31:0] instrWord,
   output logic taken
);
   // ----------------------------------------------------------------
   // offer, hold until accepted, then release the word lines
   // ----------------------------------------------------------------
   // a released word toggles every cycle so stale data never looks valid
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         instrValid <= 1'h0;
         instrWord <= 32'h0000_0000;
         taken <= 1'h0;
      end else begin
         taken <= 1'h0;
         if (instrValid && instrReady) begin
            instrValid <= 1'h0;
            instrWord <= ~instrWord;
            taken <= 1'h1;
         end else if (go && !instrValid) begin
            instrValid <= 1'h1;
            instrWord <= goWord;
         end else if (!instrValid) begin
            instrWord <= ~instrWord;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/signed_and_extended_adder_tb_top.sv */
// self-checking bench for the add unit: bus tasks and instruction rows
// assumes the unit's register port map and 4-clock instruction walk
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module signed_and_extended_adder_tb_top;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic [9:0] busAddr = 10'h000;
   logic [31:0] busWrData = 32'h0000_0000;
   logic busWr = 1'h0;
   logic busRd = 1'h0;
   logic go = 1'h0;
   logic [31:0] goWord = 32'h0000_0000;
   logic [31:0] busRdData;
   logic [31:0] instrWord;
   logic instrValid, instrReady, instrDone, zeroFlag, carryFlag, taken;
   logic [5:0] opc;
   logic [3:0] cnd;
   logic zw, rw, imm, setf;
   logic [31:0] stat;
   int fails = 0;
   int n_compared = 0;

   // ----------------------------------------------------------------
   // clock, unit and instruction source
   // ----------------------------------------------------------------
   initial begin
      forever #10 mclk = ~mclk;
   end

   add_unit DUT (.mclk(mclk), .reset(reset), .instrValid(instrValid),
      .instrWord(instrWord), .instrReady(instrReady),
      .instrDone(instrDone), .busAddr(busAddr), .busWrData(busWrData),
      .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
      .zeroFlag(zeroFlag), .carryFlag(carryFlag));

   instr_feeder feeder (.mclk(mclk), .reset(reset), .go(go),
      .goWord(goWord), .instrReady(instrReady), .instrValid(instrValid),
      .instrWord(instrWord), .taken(taken));

   // ----------------------------------------------------------------
   // register port and instruction tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk);
      busWr <= 1'h1;
      busAddr <= a;
      busWrData <= d;
      @(posedge mclk);
      busWr <= 1'h0;
   endtask

   // data stand only in the cycle after the strobe, so look there
   task automatic rd(input logic [9:0] a, output logic [31:0] d);
      @(posedge mclk);
      busRd <= 1'h1;
      busAddr <= a;
      @(posedge mclk);
      busRd <= 1'h0;
      #1 d = busRdData;
   endtask

   // walks c1..c4 after the take; bounded wait for the take itself
   task automatic exec(input logic [31:0] w);
      int k;
      k = 0;
      @(posedge mclk);
      go <= 1'h1;
      goWord <= w;
      @(posedge mclk);
      go <= 1'h0;
      // taken rises on the take edge and stands one cycle, so look now
      #1;
      while (taken !== 1'h1 && k < 20) begin
         @(posedge mclk);
         #1 k++;
      end
      `CHK(taken, 1'h1)
      `CHK({instrReady, instrDone}, 2'h0)
      @(posedge mclk);
      #1 `CHK({instrReady, instrDone}, 2'h0)
      @(posedge mclk);
      #1 `CHK({instrReady, instrDone}, 2'h1)
      @(posedge mclk);
      #1 `CHK({instrReady, instrDone}, 2'h2)
   endtask

   // f holds {old Z, old C, new Z, new C}; dest is word 1, source word 2
   task automatic row(input logic [31:0] d, input logic [31:0] s,
      input logic [3:0] f, input logic [31:0] r);
      logic [31:0] got;
      logic [31:0] w;
      w = {opc, zw, 1'h1, rw, imm, cnd, 9'h001, imm ? 9'h1FF : 9'h002};
      wr(10'h001, d);
      wr(10'h002, s);
      if (setf) wr(adder_pkg::FLAGS_ADDR, {30'h0000_0000, f[2], f[3]});
      exec(w);
      `CHK({zeroFlag, carryFlag}, f[1:0])
      rd(10'h001, got);
      `CHK(got, r)
      rd(adder_pkg::FLAGS_ADDR, got);
      `CHK(got[1:0], {f[0], f[1]})
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog and main sequence
   // ----------------------------------------------------------------
   // a few hundred cycles are expected; far more means a hang
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      report_and_stop();
   end

   initial begin
      zw = 1'h1;
      rw = 1'h1;
      imm = 1'h0;
      setf = 1'h1;
      cnd = adder_pkg::COND_ALWAYS;
      opc = adder_pkg::OP_SIGNED_ADD;
      repeat (12) @(posedge mclk);
      reset <= 1'h0;
      row(32'hFFFF_FFFF, 32'h0000_0001, 4'h2, 32'h0000_0000);
      row(32'h7FFF_FFFE, 32'h0000_0002, 4'h9, 32'h8000_0000);
      row(32'h8000_0001, 32'hFFFF_FFFE, 4'h1, 32'h7FFF_FFFF);
      row(32'h0000_0001, 32'hFFFF_FFFE, 4'h4, 32'hFFFF_FFFF);
      $display("signed add test done");
      opc = adder_pkg::OP_SIGNED_ADDC;
      row(32'hFFFF_FFFE, 32'h0000_0001, 4'h4, 32'h0000_0000);
      row(32'hFFFF_FFFE, 32'h0000_0001, 4'hE, 32'h0000_0000);
      row(32'h7FFF_FFFE, 32'h0000_0001, 4'h5, 32'h8000_0000);
      row(32'h8000_0001, 32'hFFFF_FFFE, 4'hC, 32'h8000_0000);
      $display("signed add with carry test done");
      opc = adder_pkg::OP_UNSIGNED_ADDC;
      row(32'hFFFF_FFFE, 32'h0000_0001, 4'h8, 32'hFFFF_FFFF);
      row(32'hFFFF_FFFE, 32'h0000_0001, 4'h5, 32'h0000_0000);
      row(32'hFFFF_FFFE, 32'h0000_0001, 4'hF, 32'h0000_0000);
      $display("unsigned add with carry test done");
      opc = adder_pkg::OP_SIGNED_ADD;
      rw = 1'h0;
      row(32'hFFFF_FFFF, 32'h0000_0001, 4'h6, 32'hFFFF_FFFF);
      rw = 1'h1;
      imm = 1'h1;
      zw = 1'h0;
      row(32'h0000_0001, 32'h0000_0000, 4'hE, 32'h0000_0200);
      imm = 1'h0;
      zw = 1'h1;
      cnd = 4'h0;
      row(32'h0000_0005, 32'h0000_0007, 4'hF, 32'h0000_0005);
      cnd = adder_pkg::COND_ALWAYS;
      // unknown code: no effects, sticky status bit, cleared by writing 1
      opc = 6'h3F;
      row(32'h0000_0005, 32'h0000_0007, 4'hF, 32'h0000_0005);
      rd(adder_pkg::STATUS_ADDR, stat);
      `CHK(stat, 32'h0000_0002)
      wr(adder_pkg::STATUS_ADDR, 32'h0000_0002);
      rd(adder_pkg::STATUS_ADDR, stat);
      `CHK(stat, 32'h0000_0000)
      $display("effects and condition test done");
      opc = adder_pkg::OP_UNSIGNED_ADDC;
      row(32'hFFFF_FFFF, 32'h0000_0000, 4'hF, 32'h0000_0000);
      opc = adder_pkg::OP_SIGNED_ADDC;
      setf = 1'h0;
      row(32'h7FFF_FFFF, 32'h0000_0000, 4'hD, 32'h8000_0000);
      $display("multi-word chain test done");
      report_and_stop();
   end
endmodule
`undef CHK
`default_nettype wire
